// File: verification/dau_xbar_model.sv
// crossbar model: grants after a set wait, answers loads, records traffic
`default_nettype none
module dau_xbar_model #(
	parameter logic [31:0] MEM_WORD = 32'h80f1_7f82
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// wait before each grant
	input wire logic [3:0] waitCyc,
	// global port
	input wire dau_pkg::dau_port_s gPort,
	output logic gGnt,
	output logic [31:0] gRdata,
	// local port
	input wire dau_pkg::dau_port_s lPort,
	output logic lGnt,
	output logic [31:0] lRdata,
	// traffic record
	output var dau_pkg::dau_port_s lastAcc,
	output var int gCnt,
	output var int lCnt
);
	import dau_pkg::*;
	logic [3:0] gWait;
	logic [3:0] lWait;
	// ====================
	// grants
	assign gGnt = gPort.req && (gWait == waitCyc);
	assign lGnt = lPort.req && (lWait == waitCyc);
	// ====================
	// state
	// data only in the cycle after a load grant, otherwise a toggling pattern
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gWait <= 4'h0;
			lWait <= 4'h0;
			gRdata <= 32'h0;
			lRdata <= 32'h0;
			lastAcc <= '0;
			gCnt <= 0;
			lCnt <= 0;
		end else begin
			gWait <= (gGnt || !gPort.req) ? 4'h0 : gWait + 4'h1;
			lWait <= (lGnt || !lPort.req) ? 4'h0 : lWait + 4'h1;
			gRdata <= (gGnt && !gPort.we) ? MEM_WORD : ~gRdata;
			lRdata <= (lGnt && !lPort.we) ? MEM_WORD : ~lRdata;
			gCnt <= gCnt + int'(gGnt);
			lCnt <= lCnt + int'(lGnt);
			if (gGnt) begin
				lastAcc <= gPort;
			end else if (lGnt) begin
				lastAcc <= lPort;
			end
		end
	end
endmodule // dau_xbar_model
`default_nettype wire

// File: verification/dual_address_unit_port_routing_test.sv
// testbench: scenario tasks for the address unit router and crossbar model
`default_nettype none
module dual_address_unit_port_routing_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dau_pkg::*;
	// ====================
	// signals
	localparam logic [31:0] PBA_T = 32'h0100_0010;
	localparam logic [31:0] MEM_T = 32'h80f1_7f82;
	localparam int LIMIT = 4000;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic instrValid = 1'b0;
	logic instrReady, gGnt, lGnt, stall, illegal;
	logic [3:0] waitCyc = 4'h0;
	logic [31:0] gRdata, lRdata;
	dau_instr_s instrData = '0;
	dau_instr_s ins;
	dau_port_s gPort, lPort, lastAcc;
	dau_wb_s gDst, lds, gAregWb, lAregWb, gDstQ, ldsQ, gAwbQ, lAwbQ;
	int gCnt, lCnt, g0, l0, nWb, nStall, nIll, nFull, cyc, failCount, cmpCount;
	always #5 clk_sys = ~clk_sys;
	// ====================
	// design and crossbar
	dau_top #(.PBA(PBA_T)) dau_top_inst (
		.clk_sys, .rst_n, .instrValid, .instrReady, .instrData, .gPort, .gGnt, .gRdata,
		.lPort, .lGnt, .lRdata, .gDst, .lds, .gAregWb, .lAregWb, .stall, .illegal
	);
	dau_xbar_model dau_xbar_model_inst (
		.clk_sys, .rst_n, .waitCyc, .gPort, .gGnt, .gRdata, .lPort, .lGnt, .lRdata,
		.lastAcc, .gCnt, .lCnt
	);
	// ====================
	// capture of pulses, cycle limit
	always @(negedge clk_sys) begin
		if (gDst.valid) gDstQ = gDst;
		if (lds.valid) ldsQ = lds;
		if (gAregWb.valid) gAwbQ = gAregWb;
		if (lAregWb.valid) lAwbQ = lAregWb;
		nWb = nWb + gDst.valid + lds.valid + gAregWb.valid + lAregWb.valid;
		nStall = nStall + stall;
		nIll = nIll + illegal;
		nFull = nFull + (instrValid && !instrReady);
		cyc++;
		if (cyc >= LIMIT) begin
			failCount++;
			endOfTest();
		end
	end
	// ====================
	// shared tasks
	task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic dau_unit_s mk(input dau_op_e op, input logic [3:0] md, input dau_base_e bs,
		input logic [3:0] ar, input logic [31:0] av, input logic [31:0] xv, input logic [15:0] im,
		input dau_size_e sz, input logic sx, input dau_reg_t ds, input logic [31:0] sd);
		logic lng;
		lng = (sz == DAU_SZ_BYTE) ? |im[15:4] : |im[15:3];
		mk = '{op, md, bs, ar, av, {ar[3], 3'h0}, xv, lng, im, !md[3], sz, sx, ds, sd};
	endfunction
	task automatic run(input int n);
		int k;
		k = 0;
		nWb = 0;
		nStall = 0;
		nIll = 0;
		gDstQ = '0;
		ldsQ = '0;
		gAwbQ = '0;
		lAwbQ = '0;
		g0 = gCnt;
		l0 = lCnt;
		@(negedge clk_sys);
		instrValid = 1'b1;
		instrData = ins;
		while (!instrReady && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		@(negedge clk_sys);
		instrValid = 1'b0;
		while (nWb < n && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		repeat (4) @(negedge clk_sys);
	endtask
	// ====================
	// scenarios
	task automatic t_move();
		ins = '0;
		ins.gu = mk(DAU_OP_MOVE, 4'h1, DAU_BASE_AREG, 4'h8, '0, '0, '0, DAU_SZ_HALF, 0, 6'h12,
			32'h1234_abcd);
		run(1);
		ck(gDstQ.data, 32'habcd_abcd);
		ins.gu = mk(DAU_OP_MOVE, 4'h0, DAU_BASE_AREG, 4'h8, '0, '0, 16'h1, DAU_SZ_BYTE, 1, 6'h13,
			32'h1234_8056);
		run(1);
		ck(gDstQ.data, 32'hffff_ff80);
		ck(nStall, 0);
		$display("move done");
	endtask
	task automatic t_gload();
		ins = '0;
		ins.gu = mk(DAU_OP_LOAD, 4'h2, DAU_BASE_AREG, 4'h8, 32'h1000, 32'h3, '0, DAU_SZ_HALF, 1,
			6'h20, '0);
		run(2);
		ck(lastAcc.addr, 32'h0000_1006);
		ck(gAwbQ.data, 32'h0000_1006);
		ck(gDstQ.data, 32'hffff_80f1);
		ck(gCnt - g0, 1);
		ck(nStall, 1);
		$display("global load done");
	endtask
	task automatic t_store();
		ins = '0;
		ins.gu = mk(DAU_OP_STORE, 4'hd, DAU_BASE_PBA, 4'h9, '0, '0, 16'h5, DAU_SZ_BYTE, 0, 6'h0,
			32'h0000_00a7);
		run(1);
		ck(lastAcc.addr, PBA_T);
		ck(lastAcc.wdata, 32'ha7a7_a7a7);
		ck({28'h0, lastAcc.strb}, 32'h1);
		ck(gAwbQ.data, PBA_T - 32'h5);
		ins.gu = mk(DAU_OP_STORE, 4'h8, DAU_BASE_DBA, 4'h9, '0, '0, 16'hfff1, DAU_SZ_BYTE, 0,
			6'h0, 32'h0000_00c3);
		run(0);
		ck(lastAcc.addr, 32'h0000_fff1);
		ck({28'h0, lastAcc.strb}, 32'h2);
		ck(nWb, 0);
		$display("store done");
	endtask
	task automatic t_dual();
		for (int k = 0; k < 2; k++) begin
			ins = '0;
			ins.gu = mk(DAU_OP_LOAD, 4'h0, DAU_BASE_AREG, 4'h8, 32'h2000, '0, '0, DAU_SZ_WORD, 0,
				6'h21, '0);
			ins.lu = mk(DAU_OP_LOAD, 4'h0, DAU_BASE_AREG, 4'h1, k ? 32'h0010_0000 : 32'h40, '0,
				'0, DAU_SZ_WORD, 0, 6'h3, '0);
			run(2);
			ck(nStall, k ? 2 : 1);
			ck(gCnt - g0, k ? 2 : 1);
			ck(lCnt - l0, k ? 0 : 1);
			ck(ldsQ.data, MEM_T);
			ck(gDstQ.data, MEM_T);
		end
		$display("dual transfer done");
	endtask
	task automatic t_lone();
		ins = '0;
		ins.lu = mk(DAU_OP_STORE, 4'ha, DAU_BASE_AREG, 4'h2, 32'h0010_0000, '0, 16'h2,
			DAU_SZ_HALF, 0, 6'h4, 32'h9999_5678);
		run(1);
		ck(lAwbQ.data, 32'h0010_0002);
		ck(gCnt - g0, 1);
		ck(lCnt - l0, 0);
		ck(lastAcc.wdata, 32'h5678_5678);
		ck({28'h0, lastAcc.strb}, 32'hc);
		ins.lu.op = DAU_OP_LOAD;
		run(2);
		ck(ldsQ.data, 32'h0000_80f1);
		ins.lu = mk(DAU_OP_ARITH, 4'h8, DAU_BASE_AREG, 4'h2, 32'h100, '0, 16'h4, DAU_SZ_WORD, 0,
			6'h10, '0);
		run(1);
		ck(gDstQ.data, 32'h104);
		ins.gu = mk(DAU_OP_ARITH, 4'h8, DAU_BASE_AREG, 4'ha, 32'h200, '0, 16'h7, DAU_SZ_WORD, 0,
			6'h11, '0);
		ins.lu.dst = 6'h5;
		run(2);
		ck(ldsQ.data, 32'h104);
		ck(gDstQ.data, 32'h207);
		$display("lone local done");
	endtask
	task automatic t_illegal();
		for (int k = 0; k < 7; k++) begin
			ins = '0;
			ins.gu = mk(DAU_OP_LOAD, 4'h2, DAU_BASE_AREG, 4'h8, 32'h300, '0, '0, DAU_SZ_WORD, 0,
				6'h22, '0);
			ins.lu = mk(DAU_OP_LOAD, 4'h0, DAU_BASE_AREG, 4'h1, 32'h40, '0, '0, DAU_SZ_WORD, 0,
				6'h2, '0);
			case (k)
				0: ins.lu.aReg = 4'h5;
				1: ins.gu.aReg = 4'hd;
				2: ins.gu.xReg = 4'hb;
				3: ins.cond = 1'b1;
				4: ins.duNonD = 1'b1;
				5: ins.gu.mode = 4'h6;
				default: begin
					ins.gu.op = DAU_OP_NONE;
					ins.duNonD = 1'b1;
					ins.lu.dst = 6'h9;
				end
			endcase
			run(0);
			ck(nIll, 1);
			ck(nWb + gCnt + lCnt - g0 - l0, 0);
		end
		$display("forbidden combinations done");
	endtask
	task automatic t_fifo();
		int n;
		int k;
		n = 0;
		k = 0;
		ins = '0;
		ins.gu = mk(DAU_OP_STORE, 4'h0, DAU_BASE_AREG, 4'h8, 32'h3000, '0, '0, DAU_SZ_WORD, 0,
			6'h0, 32'h1357_9bdf);
		g0 = gCnt;
		@(negedge clk_sys);
		waitCyc = 4'h3;
		nFull = 0;
		nStall = 0;
		instrData = ins;
		instrValid = 1'b1;
		while (n < 6 && k < 200) begin
			if (instrReady) n++;
			k++;
			@(negedge clk_sys);
		end
		instrValid = 1'b0;
		while (gCnt - g0 < 6 && k < 200) begin
			@(negedge clk_sys);
			k++;
		end
		repeat (4) @(negedge clk_sys);
		ck(gCnt - g0, 6);
		ck(nFull > 0, 1);
		ck(nStall >= 24, 1);
		ck({28'h0, lastAcc.strb}, 32'hf);
		waitCyc = 4'h0;
		$display("buffer fill done");
	endtask
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ====================
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		t_move();
		t_gload();
		t_store();
		t_dual();
		t_lone();
		t_illegal();
		t_fifo();
		endOfTest();
	end
endmodule // dual_address_unit_port_routing_test
`default_nettype wire

// File: verilog/dau_fifo.sv
// fifo: flip-flop buffer with valid/ready on both sides
`default_nettype none
module dau_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outValid = count_q != '0;
	assign outData = mem[rdPtr_q];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			inReady <= 1'b0;
		end else begin
			if (push) wrPtr_q <= wrPtr_q + 1'b1;
			if (pop) rdPtr_q <= rdPtr_q + 1'b1;
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
			inReady <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) mem[wrPtr_q] <= inData;
	end
	a_fifo_bounds: assert property (@(posedge clk_sys) disable iff (!rst_n)
		count_q == (AW+1)'(DEPTH) |-> !inReady)
		else $error("fifo full but still ready");
endmodule // dau_fifo
`default_nettype wire

// File: verilog/dau_pkg.sv
// package: types and constants of the dual address unit router
// Operation
// - Replicate byte x4 or halfword x2 on stores.
// - Align then sign or zero extend loads, moves.
// - Global source replicate also serves register moves.
// - Local bus moves D data or local arithmetic.
// - Lone local store uses global data port.
// - Lone local D load returns via global port.
// - Register move completes in one cycle.
// - Arithmetic results route to destination buses.
// - Lone local result may reach any register.
// - Otherwise local unit register must be D.
// - Each unit uses its own register subset.
// - Dual transfer, remote local address: two cycles.
// - Non-D data operands displace global unit.
// - Conditional operations forbid parallel local unit.
// - Twelve modes; address then execute stage.
// - Base plus scaled index or immediate, 32 bits.
// - Pre-index sends sum, post-index sends base.
// - Optional sum written back to address register.
// - Address issued in address cycle; data later.
// - Global unit always on global port.
// - Busy global port: local port, else divert.
// - Two hardwired per-core relative bases.
// - Scale index by one or two bits.
// - Immediate widths 3/15 or 4/16 bits.
// - Write strobes select addressed byte or halfword.
`default_nettype none
package dau_pkg;
	// ====================
	// sizes and defaults
	localparam int DAU_DW = 32;
	localparam int DAU_FIFO_DEPTH = 4;
	localparam logic [31:0] DAU_PBA_DEF = 32'h0100_0000;
	localparam logic [31:0] DAU_DBA_DEF = 32'h0000_0000;
	localparam logic [31:0] DAU_LRAM_BASE_DEF = 32'h0000_0000;
	localparam logic [31:0] DAU_LRAM_MASK_DEF = 32'hffff_8000;
	// ====================
	// immediate widths and index scaling
	localparam int DAU_SHORT_HW = 3;
	localparam int DAU_SHORT_B = 4;
	localparam int DAU_LONG_HW = 15;
	localparam int DAU_LONG_B = 16;
	localparam logic [1:0] DAU_SCALE_HALF = 2'h1;
	localparam logic [1:0] DAU_SCALE_WORD = 2'h2;
	// ====================
	// register subsets
	localparam logic [3:0] DAU_AREG_SKIP_L = 4'h5;
	localparam logic [3:0] DAU_AREG_SKIP_G = 4'hd;
	localparam logic [3:0] DAU_XREG_MAX_L = 4'h2;
	localparam logic [3:0] DAU_XREG_MIN_G = 4'h8;
	localparam logic [3:0] DAU_XREG_MAX_G = 4'ha;
	localparam logic [2:0] DAU_DREG_GROUP = 3'h0;
	// ====================
	// mode field: [3] immediate, [2:1] kind, [0] subtract
	localparam int DAU_MODE_IMM = 3;
	localparam logic [1:0] DAU_KIND_PRE = 2'h0;
	localparam logic [1:0] DAU_KIND_PREWB = 2'h1;
	localparam logic [1:0] DAU_KIND_POSTWB = 2'h2;
	localparam logic [1:0] DAU_KIND_BAD = 2'h3;
	// ====================
	// types
	typedef enum logic [1:0] {
		DAU_SZ_BYTE = 2'b00, DAU_SZ_HALF = 2'b01, DAU_SZ_WORD = 2'b10
	} dau_size_e;
	typedef enum logic [2:0] {
		DAU_OP_NONE = 3'b000, DAU_OP_LOAD = 3'b001, DAU_OP_STORE = 3'b010,
		DAU_OP_ARITH = 3'b011, DAU_OP_MOVE = 3'b100
	} dau_op_e;
	typedef enum logic [1:0] {
		DAU_BASE_AREG = 2'b00, DAU_BASE_PBA = 2'b01, DAU_BASE_DBA = 2'b10
	} dau_base_e;
	typedef enum logic [1:0] {
		DAU_ST_IDLE = 2'b00, DAU_ST_ISSUE = 2'b01, DAU_ST_DIVERT = 2'b10
	} dau_state_e;
	typedef logic [5:0] dau_reg_t;
	typedef struct packed {
		dau_op_e op;
		logic [3:0] mode;
		dau_base_e baseSel;
		logic [3:0] aReg;
		logic [31:0] aVal;
		logic [3:0] xReg;
		logic [31:0] xVal;
		logic longImm;
		logic [15:0] imm;
		logic scale;
		dau_size_e size;
		logic sext;
		dau_reg_t dst;
		logic [31:0] sData;
	} dau_unit_s;
	typedef struct packed {
		dau_unit_s gu;
		dau_unit_s lu;
		logic duNonD;
		logic cond;
	} dau_instr_s;
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
	} dau_port_s;
	typedef struct packed {
		logic valid;
		dau_reg_t dst;
		logic [31:0] data;
	} dau_wb_s;
	typedef struct packed {
		logic valid;
		dau_size_e size;
		logic sext;
		logic [1:0] off;
		logic toLds;
		dau_reg_t dst;
	} dau_exec_s;
endpackage
`default_nettype wire

// File: verilog/dau_top.sv
// top: address generation and port routing for the local and global address units
`default_nettype none
module dau_top #(
	parameter logic [31:0] PBA = dau_pkg::DAU_PBA_DEF,
	parameter logic [31:0] DBA = dau_pkg::DAU_DBA_DEF,
	parameter logic [31:0] LRAM_BASE = dau_pkg::DAU_LRAM_BASE_DEF,
	parameter logic [31:0] LRAM_MASK = dau_pkg::DAU_LRAM_MASK_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// instruction stream
	input wire logic instrValid,
	output logic instrReady,
	input wire dau_pkg::dau_instr_s instrData,
	// global memory port
	output var dau_pkg::dau_port_s gPort,
	input wire logic gGnt,
	input wire logic [31:0] gRdata,
	// local memory port
	output var dau_pkg::dau_port_s lPort,
	input wire logic lGnt,
	input wire logic [31:0] lRdata,
	// register writes
	output var dau_pkg::dau_wb_s gDst,
	output var dau_pkg::dau_wb_s lds,
	output var dau_pkg::dau_wb_s gAregWb,
	output var dau_pkg::dau_wb_s lAregWb,
	// pipeline status
	output logic stall,
	output logic illegal
);
	import dau_pkg::*;

	if (PBA[1:0] != 2'b00 || DBA[1:0] != 2'b00) begin : g_bad_base
		$error("relative bases must be word aligned");
	end

	// ====================
	// data helpers
	function automatic logic [31:0] replicate(input logic [31:0] d, input dau_size_e sz);
		case (sz)
			DAU_SZ_BYTE: replicate = {4{d[7:0]}};
			DAU_SZ_HALF: replicate = {2{d[15:0]}};
			default: replicate = d;
		endcase
	endfunction

	function automatic logic [3:0] strobes(input dau_size_e sz, input logic [1:0] off);
		case (sz)
			DAU_SZ_BYTE: strobes = 4'h1 << off;
			DAU_SZ_HALF: strobes = off[1] ? 4'hc : 4'h3;
			default: strobes = 4'hf;
		endcase
	endfunction

	function automatic logic [31:0] alignExt(input logic [31:0] d, input logic [1:0] off,
		input dau_size_e sz, input logic sx);
		logic [31:0] sh;
		sh = d >> {(sz == DAU_SZ_HALF) ? {off[1], 1'b0} : off, 3'b000};
		case (sz)
			DAU_SZ_BYTE: alignExt = {{24{sx & sh[7]}}, sh[7:0]};
			DAU_SZ_HALF: alignExt = {{16{sx & sh[15]}}, sh[15:0]};
			default: alignExt = d;
		endcase
	endfunction

	function automatic logic isD(input dau_reg_t r);
		isD = r[5:3] == DAU_DREG_GROUP;
	endfunction

	function automatic logic isMem(input dau_op_e op);
		isMem = op == DAU_OP_LOAD || op == DAU_OP_STORE;
	endfunction

	// ====================
	// instruction buffer
	logic fifoValid;
	logic accept;
	dau_instr_s ins;
	dau_fifo #(.WIDTH($bits(dau_instr_s)), .DEPTH(DAU_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(instrValid),
		.inReady(instrReady),
		.inData(instrData),
		.outValid(fifoValid),
		.outReady(accept),
		.outData(ins)
	);

	// ====================
	// address generation, index 0 local, 1 global
	dau_unit_s u [2];
	logic [31:0] agAddr [2];
	logic [31:0] agNext [2];
	logic agWb [2];
	logic [1:0] modeBad;
	assign u[0] = ins.lu;
	assign u[1] = ins.gu;

	always_comb begin
		logic [31:0] base;
		logic [31:0] idx;
		logic [31:0] sum;
		base = '0;
		idx = '0;
		sum = '0;
		for (int i = 0; i < 2; i++) begin
			case (u[i].baseSel)
				DAU_BASE_PBA: base = PBA;
				DAU_BASE_DBA: base = DBA;
				default: base = u[i].aVal;
			endcase
			if (u[i].mode[DAU_MODE_IMM]) begin
				if (u[i].size == DAU_SZ_BYTE)
					idx = u[i].longImm ? 32'(u[i].imm[DAU_LONG_B-1:0])
						: 32'(u[i].imm[DAU_SHORT_B-1:0]);
				else
					idx = u[i].longImm ? 32'(u[i].imm[DAU_LONG_HW-1:0])
						: 32'(u[i].imm[DAU_SHORT_HW-1:0]);
			end else begin
				idx = u[i].xVal;
			end
			if (u[i].scale && u[i].size == DAU_SZ_HALF) idx = idx << DAU_SCALE_HALF;
			if (u[i].scale && u[i].size == DAU_SZ_WORD) idx = idx << DAU_SCALE_WORD;
			sum = u[i].mode[0] ? base - idx : base + idx;
			agAddr[i] = (u[i].mode[2:1] == DAU_KIND_POSTWB) ? base : sum;
			agNext[i] = sum;
			agWb[i] = u[i].mode[2:1] != DAU_KIND_PRE;
			modeBad[i] = u[i].mode[2:1] == DAU_KIND_BAD;
		end
	end

	// ====================
	// decode checks
	logic ill;
	logic lAct;
	logic gAct;
	always_comb begin
		lAct = u[0].op != DAU_OP_NONE;
		gAct = u[1].op != DAU_OP_NONE;
		ill = 1'b0;
		if (lAct) begin
			if (u[0].op == DAU_OP_MOVE || modeBad[0]) ill = 1'b1;
			if (u[0].baseSel == DAU_BASE_AREG && (u[0].aReg[3] || u[0].aReg == DAU_AREG_SKIP_L))
				ill = 1'b1;
			if (!u[0].mode[DAU_MODE_IMM] && u[0].xReg > DAU_XREG_MAX_L) ill = 1'b1;
			if (ins.cond) ill = 1'b1;
			if ((gAct || ins.duNonD) && !isD(u[0].dst)) ill = 1'b1;
		end
		if (gAct) begin
			if (u[1].op != DAU_OP_MOVE && modeBad[1]) ill = 1'b1;
			if (u[1].op != DAU_OP_MOVE && u[1].baseSel == DAU_BASE_AREG
				&& (!u[1].aReg[3] || u[1].aReg == DAU_AREG_SKIP_G)) ill = 1'b1;
			if (u[1].op != DAU_OP_MOVE && !u[1].mode[DAU_MODE_IMM]
				&& (u[1].xReg < DAU_XREG_MIN_G || u[1].xReg > DAU_XREG_MAX_G)) ill = 1'b1;
			if (ins.duNonD) ill = 1'b1;
		end
	end

	// ====================
	// routing decisions
	dau_state_e state_q;
	dau_state_e state_d;
	dau_exec_s gExec_q;
	dau_exec_s lExec_q;
	logic both;
	logic lIsLocal;
	logic divert_d;
	logic divert_q;
	dau_port_s gReq;
	dau_port_s lReq;
	dau_exec_s gInfo;
	dau_exec_s lInfo;
	dau_exec_s gInfo_q;
	dau_exec_s lInfo_q;
	dau_port_s divReq_q;
	dau_exec_s divInfo_q;
	logic issueDone;

	assign accept = fifoValid && state_q == DAU_ST_IDLE && !gExec_q.valid && !lExec_q.valid;
	assign both = isMem(u[0].op) && isMem(u[1].op);
	assign lIsLocal = (agAddr[0] & LRAM_MASK) == LRAM_BASE;
	assign divert_d = accept && !ill && both && !lIsLocal;
	assign issueDone = (!gPort.req || gGnt) && (!lPort.req || lGnt);

	always_comb begin
		dau_unit_s s;
		logic k;
		k = !isMem(u[1].op);
		s = k ? u[0] : u[1];
		gReq.req = accept && !ill && isMem(s.op);
		gReq.we = s.op == DAU_OP_STORE;
		gReq.addr = k ? agAddr[0] : agAddr[1];
		gReq.wdata = replicate(s.sData, s.size);
		gReq.strb = strobes(s.size, gReq.addr[1:0]);
		gInfo = '{valid: 1'b1, size: s.size, sext: s.sext, off: gReq.addr[1:0],
			toLds: k && isD(s.dst), dst: s.dst};
		lReq.req = accept && !ill && both;
		lReq.we = u[0].op == DAU_OP_STORE;
		lReq.addr = agAddr[0];
		lReq.wdata = replicate(u[0].sData, u[0].size);
		lReq.strb = strobes(u[0].size, agAddr[0][1:0]);
		lInfo = '{valid: 1'b1, size: u[0].size, sext: u[0].sext, off: agAddr[0][1:0],
			toLds: 1'b1, dst: u[0].dst};
	end

	// ====================
	// sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			DAU_ST_IDLE: if (gReq.req || lReq.req) state_d = DAU_ST_ISSUE;
			DAU_ST_ISSUE: if (issueDone) state_d = divert_q ? DAU_ST_DIVERT : DAU_ST_IDLE;
			DAU_ST_DIVERT: if (gGnt) state_d = DAU_ST_IDLE;
			default: state_d = DAU_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= DAU_ST_IDLE;
			stall <= 1'b0;
			illegal <= 1'b0;
		end else begin
			state_q <= state_d;
			stall <= state_d != DAU_ST_IDLE;
			illegal <= accept && ill;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			divert_q <= 1'b0;
			divReq_q <= '0;
			divInfo_q <= '0;
		end else if (accept) begin
			divert_q <= divert_d;
			divReq_q <= lReq;
			divReq_q.req <= 1'b1;
			divInfo_q <= lInfo;
			divInfo_q.toLds <= 1'b0;
		end
	end

	// ====================
	// memory ports
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gPort <= '0;
			gInfo_q <= '0;
		end else if (accept) begin
			gPort <= gReq;
			gInfo_q <= gInfo;
		end else if (state_q == DAU_ST_ISSUE && issueDone && divert_q) begin
			gPort <= divReq_q;
			gInfo_q <= divInfo_q;
			gInfo_q.toLds <= 1'b1;
		end else if (gGnt) begin
			gPort.req <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lPort <= '0;
			lInfo_q <= '0;
		end else if (accept) begin
			lPort <= lIsLocal ? lReq : '0;
			lInfo_q <= lInfo;
		end else if (lGnt) begin
			lPort.req <= 1'b0;
		end
	end

	// ====================
	// execute stage: load data returns the cycle after the grant
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gExec_q <= '0;
			lExec_q <= '0;
		end else begin
			gExec_q <= gInfo_q;
			gExec_q.valid <= gPort.req && gGnt && !gPort.we;
			lExec_q <= lInfo_q;
			lExec_q.valid <= lPort.req && lGnt && !lPort.we;
		end
	end

	// ====================
	// register writes
	logic [31:0] gLoad;
	logic [31:0] moveVal;
	logic lArithAny;
	assign gLoad = alignExt(gRdata, gExec_q.off, gExec_q.size, gExec_q.sext);
	assign moveVal = u[1].mode[0] ? replicate(u[1].sData, u[1].size)
		: alignExt(u[1].sData, u[1].imm[1:0], u[1].size, u[1].sext);
	assign lArithAny = !gAct && !ins.duNonD && !isD(u[0].dst);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gDst <= '0;
		end else if (gExec_q.valid && !gExec_q.toLds) begin
			gDst <= '{valid: 1'b1, dst: gExec_q.dst, data: gLoad};
		end else if (accept && !ill && u[1].op == DAU_OP_MOVE) begin
			gDst <= '{valid: 1'b1, dst: u[1].dst, data: moveVal};
		end else if (accept && !ill && u[1].op == DAU_OP_ARITH) begin
			gDst <= '{valid: 1'b1, dst: u[1].dst, data: agAddr[1]};
		end else if (accept && !ill && u[0].op == DAU_OP_ARITH && lArithAny) begin
			gDst <= '{valid: 1'b1, dst: u[0].dst, data: agAddr[0]};
		end else begin
			gDst.valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lds <= '0;
		end else if (lExec_q.valid) begin
			lds <= '{valid: 1'b1, dst: lExec_q.dst,
				data: alignExt(lRdata, lExec_q.off, lExec_q.size, lExec_q.sext)};
		end else if (gExec_q.valid && gExec_q.toLds) begin
			lds <= '{valid: 1'b1, dst: gExec_q.dst, data: gLoad};
		end else if (accept && !ill && u[0].op == DAU_OP_ARITH && !lArithAny) begin
			lds <= '{valid: 1'b1, dst: u[0].dst, data: agAddr[0]};
		end else begin
			lds.valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gAregWb <= '0;
			lAregWb <= '0;
		end else begin
			gAregWb <= '{valid: accept && !ill && gAct && u[1].op != DAU_OP_MOVE && agWb[1],
				dst: 6'(u[1].aReg), data: agNext[1]};
			lAregWb <= '{valid: accept && !ill && lAct && agWb[0],
				dst: 6'(u[0].aReg), data: agNext[0]};
		end
	end

	// ====================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_divStart;
		accept && divert_d;
	endsequence
	sequence s_divHold;
		!lPort.req && stall;
	endsequence

	a_repl_fill: assert property (gPort.req && gPort.we && $onehot(gPort.strb) |->
		gPort.wdata[31:24] == gPort.wdata[7:0] && gPort.wdata[15:8] == gPort.wdata[7:0])
		else $error("byte store not replicated");
	a_strobe_addr: assert property (gPort.req && gPort.we |->
		(gPort.strb & ~(4'hf << gPort.addr[1:0])) == 4'h0)
		else $error("strobe outside addressed lanes");
	a_local_range: assert property (lPort.req |-> (lPort.addr & LRAM_MASK) == LRAM_BASE)
		else $error("local port used for remote address");
	a_divert_two: assert property (s_divStart |=> s_divHold)
		else $error("remote local access not held back");
	a_divert_stall: assert property (state_q == DAU_ST_DIVERT |-> stall)
		else $error("stall dropped while divert pending");
	a_move_once: assert property (accept && !ill && u[1].op == DAU_OP_MOVE |=>
		gDst.valid && gDst.data == $past(moveVal) ##1 (!gDst.valid || $past(accept)))
		else $error("move not written in one cycle");
	a_cond_local: assert property (accept && ins.cond && lAct |=> illegal && !lPort.req)
		else $error("conditional with local op accepted");
	a_local_dreg: assert property (accept && lAct && (gAct || ins.duNonD) && !isD(u[0].dst)
		|=> illegal)
		else $error("local unit non-D register accepted");
	a_global_first: assert property (accept && !ill && isMem(u[1].op) |=>
		gPort.req && gPort.addr == $past(agAddr[1]))
		else $error("global unit not on global port");
	a_exec_after: assert property (gPort.req && gGnt && !gPort.we |=> gExec_q.valid)
		else $error("execute stage missed granted load");
endmodule // dau_top
`default_nettype wire
